/* File: src/pcr_buf2.v */
// two-entry buffer with valid/ready on both sides, registered outputs
// assumes one clock; the head entry drives the outputs directly
`timescale 1ns/1ns
module pcr_buf2 #(
  parameter W = 32
) (
  // clock and reset
  input  wire         sys_clk,
  input  wire         rst,
  // filling side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // draining side
  output reg          out_valid,
  input  wire         out_ready,
  output reg  [W-1:0] out_data
);

  reg         spare_vld_q;
  reg [W-1:0] spare_q;
  wire        push;
  wire        pop;

  // ready only depends on the spare slot, so no combinational path
  assign in_ready = ~spare_vld_q;
  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;

  always @(posedge sys_clk) begin
    if (rst) begin
      out_valid   <= 1'b0;
      out_data    <= {W{1'b0}};
      spare_vld_q <= 1'b0;
      spare_q     <= {W{1'b0}};
    end else if (!out_valid || pop) begin
      if (spare_vld_q) begin
        out_valid   <= 1'b1;
        out_data    <= spare_q;
        spare_vld_q <= push;
        if (push)
          spare_q <= in_data;
      end else begin
        out_valid <= push;
        if (push)
          out_data <= in_data;
      end
    end else if (push) begin
      spare_vld_q <= 1'b1;
      spare_q     <= in_data;
    end
  end

endmodule // pcr_buf2

/* File: src/pcr_defines.vh */
// constants of the packet capture receiver: register map, fields, timing
// assumes inclusion by bare name from every design file that needs them
`ifndef PCR_DEFINES_VH
`define PCR_DEFINES_VH

// register offsets (byte addresses on the plain register port)
`define PCR_ADDR_W           4
`define PCR_OFS_GLB_CTRL     4'h0
`define PCR_OFS_DEST_BASE    4'h4
`define PCR_OFS_WORD_CNT     4'h8
`define PCR_OFS_PKT_CNT      4'hc

// global_control_register fields
`define PCR_ONOFF_LSB        0
`define PCR_ONOFF_MSB        3
`define PCR_WIDTH_LSB        4
`define PCR_WIDTH_MSB        6
`define PCR_BUSY_BIT         8
`define PCR_OVFL_BIT         9
`define PCR_ONOFF_OFF        4'h5
`define PCR_ONOFF_ON         4'ha
`define PCR_ONOFF_RST        4'h5
`define PCR_WIDTH_RST        3'h0

// port width codes
`define PCR_W1               3'h0
`define PCR_W2               3'h1
`define PCR_W4               3'h2
`define PCR_W8               3'h3
`define PCR_W16              3'h4

// packet and timing figures, in bits, pins and port clock edges
`define PCR_MAX_PKT_BITS     7'h58
`define PCR_TAIL_EDGES       2'h3
`define PCR_WORD_BITS        5'h10
`define PCR_PORT_W           16
`define PCR_MEM_AW           16

`endif

/* File: src/pcr_receiver.v */
// packet capture receiver: port sampling, deserialiser, memory writer
// assumes port_clock well below sys_clk/4 and free running during frames
//
// Overview of operation
// - busy rises when packet reception starts
// - busy holds until buffers empty and idle
// - on/off code 0101 switches module off
// - off mid-packet still completes and drains data
// - deserialise packet into buffers, then memory
// - trace packets at most 88 bits
// - width one: 91 port edges per packet
// - width sixteen: 9 port edges per packet
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ns
`include "pcr_defines.vh"
module pcr_receiver (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // external packet port
  input  wire        port_clock,
  input  wire        port_frame,
  input  wire [15:0] port_data,
  // destination memory write path
  output wire        mem_wr_valid,
  input  wire        mem_wr_ready,
  output wire [15:0] mem_wr_addr,
  output wire [15:0] mem_wr_data
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RECV = 3'b010;
  localparam [2:0] ST_TAIL = 3'b100;

  // synchronised port pins
  wire [17:0] pins_s;
  wire        pclk_s;
  wire        frame_s;
  wire [15:0] data_s;
  reg         pclk_prev_q;
  wire        pedge;

  // registers
  reg  [3:0]  onoff_q;
  reg  [2:0]  width_q;
  reg  [15:0] dest_base_q;
  reg  [15:0] word_cnt_q;
  reg  [15:0] pkt_cnt_q;
  reg         ovfl_q;
  reg         busy_q;
  wire        module_on;

  // deserialiser
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [2:0]  pkt_width_q;
  reg  [15:0] shreg_q;
  reg  [15:0] shreg_d;
  reg  [4:0]  fill_q;
  reg  [4:0]  fill_d;
  reg  [6:0]  bits_q;
  reg  [6:0]  bits_d;
  reg  [4:0]  add_bits;
  reg  [15:0] appended;
  reg  [1:0]  tail_q;
  reg  [1:0]  tail_d;
  reg         word_new;
  reg  [15:0] word_val;
  reg         pkt_done;
  reg         take;

  // hold register in front of the buffer
  reg         hold_vld_q;
  reg  [31:0] hold_q;
  reg  [15:0] cur_addr_q;
  wire        buf_in_ready;
  wire [31:0] buf_out;

  assign module_on = (onoff_q != `PCR_ONOFF_OFF);

  pcr_sync2 #(
    .W (18)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({port_clock, port_frame, port_data}),
    .sync_out (pins_s)
  );

  assign pclk_s  = pins_s[17];
  assign frame_s = pins_s[16];
  assign data_s  = pins_s[15:0];
  assign pedge   = pclk_s & ~pclk_prev_q;

  // resets to the pin's idle low level, so reset makes no false edge
  always @(posedge sys_clk) begin
    if (rst)
      pclk_prev_q <= 1'b0;
    else
      pclk_prev_q <= pclk_s;
  end

  // bits taken per port edge, per configured width
  always @* begin
    case (pkt_width_q)
      `PCR_W1: begin
        add_bits = 5'd1;
        appended = {shreg_q[14:0], data_s[0]};
      end
      `PCR_W2: begin
        add_bits = 5'd2;
        appended = {shreg_q[13:0], data_s[1:0]};
      end
      `PCR_W4: begin
        add_bits = 5'd4;
        appended = {shreg_q[11:0], data_s[3:0]};
      end
      `PCR_W8: begin
        add_bits = 5'd8;
        appended = {shreg_q[7:0], data_s[7:0]};
      end
      default: begin
        add_bits = `PCR_WORD_BITS;
        appended = data_s;
      end
    endcase
  end

  // receive state machine, advanced only on port clock edges
  always @* begin
    state_d  = state_q;
    shreg_d  = shreg_q;
    fill_d   = fill_q;
    bits_d   = bits_q;
    tail_d   = tail_q;
    take     = 1'b0;
    word_new = 1'b0;
    word_val = appended;
    pkt_done = 1'b0;
    if (pedge) begin
      case (state_q)
        ST_IDLE: begin
          // new packets only start while switched on; first beat is data
          if (frame_s && module_on) begin
            state_d = ST_RECV;
            take    = 1'b1;
          end
        end
        ST_RECV: begin
          // keeps running when switched off mid-packet
          if (!frame_s) begin
            state_d = ST_TAIL;
            tail_d  = 2'd1;
          end else begin
            take = 1'b1;
          end
        end
        ST_TAIL: begin
          // low-frame edge is tail edge one: 88+3 and 6+3 edges
          if (tail_q == `PCR_TAIL_EDGES - 2'd1) begin
            state_d  = ST_IDLE;
            pkt_done = 1'b1;
            if (fill_q != 5'd0) begin
              word_new = 1'b1;
              word_val = shreg_q;
            end
            // idle holds a clean slate, the next start shifts at once
            shreg_d = 16'h0000;
            fill_d  = 5'd0;
            bits_d  = 7'd0;
            tail_d  = 2'd0;
          end else begin
            tail_d = tail_q + 2'd1;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
      // one shift step per data beat; beats past the limit are dropped
      if (take && bits_q < `PCR_MAX_PKT_BITS) begin
        bits_d = bits_q + {2'b00, add_bits};
        if (fill_q + add_bits >= `PCR_WORD_BITS) begin
          word_new = 1'b1;
          word_val = appended;
          fill_d   = 5'd0;
          shreg_d  = 16'h0000;
        end else begin
          fill_d  = fill_q + add_bits;
          shreg_d = appended;
        end
      end
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      pkt_width_q <= `PCR_WIDTH_RST;
      shreg_q     <= 16'h0000;
      fill_q      <= 5'd0;
      bits_q      <= 7'd0;
      tail_q      <= 2'd0;
    end else begin
      state_q <= state_d;
      shreg_q <= shreg_d;
      fill_q  <= fill_d;
      bits_q  <= bits_d;
      tail_q  <= tail_d;
      // width frozen per packet so a reconfigure cannot split a word
      if (state_q == ST_IDLE)
        pkt_width_q <= width_q;
    end
  end

  // hold register: one word of slack ahead of the two-entry buffer
  always @(posedge sys_clk) begin
    if (rst) begin
      hold_vld_q <= 1'b0;
      hold_q     <= 32'h00000000;
    end else if (word_new) begin
      hold_vld_q <= 1'b1;
      hold_q     <= {cur_addr_q, word_val};
    end else if (buf_in_ready) begin
      hold_vld_q <= 1'b0;
    end
  end

  pcr_buf2 #(
    .W (32)
  ) u_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (hold_vld_q),
    .in_ready  (buf_in_ready),
    .in_data   (hold_q),
    .out_valid (mem_wr_valid),
    .out_ready (mem_wr_ready),
    .out_data  (buf_out)
  );

  assign mem_wr_addr = buf_out[31:16];
  assign mem_wr_data = buf_out[15:0];

  // busy covers reception, hold slot and both buffer entries
  always @(posedge sys_clk) begin
    if (rst)
      busy_q <= 1'b0;
    else
      busy_q <= (state_q != ST_IDLE) | hold_vld_q | mem_wr_valid
                | word_new;
  end

  // register writes
  always @(posedge sys_clk) begin
    if (rst) begin
      onoff_q     <= `PCR_ONOFF_RST;
      width_q     <= `PCR_WIDTH_RST;
      dest_base_q <= 16'h0000;
      cur_addr_q  <= 16'h0000;
      word_cnt_q  <= 16'h0000;
      pkt_cnt_q   <= 16'h0000;
      ovfl_q      <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `PCR_OFS_GLB_CTRL) begin
        // busy bit position is ignored on write
        onoff_q <= reg_wdata[`PCR_ONOFF_MSB:`PCR_ONOFF_LSB];
        width_q <= reg_wdata[`PCR_WIDTH_MSB:`PCR_WIDTH_LSB];
      end
      if (reg_wr && reg_addr == `PCR_OFS_DEST_BASE)
        dest_base_q <= reg_wdata[15:0];
      // new base also restarts the write pointer; a word made now wins
      if (word_new)
        cur_addr_q <= cur_addr_q + 16'h0001;
      else if (reg_wr && reg_addr == `PCR_OFS_DEST_BASE)
        cur_addr_q <= reg_wdata[15:0];
      if (word_new)
        word_cnt_q <= word_cnt_q + 16'h0001;
      if (pkt_done)
        pkt_cnt_q <= pkt_cnt_q + 16'h0001;
      // a word lost to a full hold slot; set wins over the clear
      if (word_new && hold_vld_q && !buf_in_ready)
        ovfl_q <= 1'b1;
      else if (reg_wr && reg_addr == `PCR_OFS_GLB_CTRL &&
               reg_wdata[`PCR_OVFL_BIT])
        ovfl_q <= 1'b0;
    end
  end

  // register reads, data valid the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `PCR_OFS_GLB_CTRL:
          reg_rdata <= {22'h000000, ovfl_q, busy_q, 1'b0, width_q,
                        onoff_q};
        `PCR_OFS_DEST_BASE:
          reg_rdata <= {16'h0000, dest_base_q};
        `PCR_OFS_WORD_CNT:
          reg_rdata <= {16'h0000, word_cnt_q};
        `PCR_OFS_PKT_CNT:
          reg_rdata <= {16'h0000, pkt_cnt_q};
        default:
          reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // pcr_receiver

/* File: src/pcr_sync2.v */
// two flip-flop synchroniser for a bundle of asynchronous inputs
// assumes each bit is a slow level or a clock far below sys_clk
`timescale 1ns/1ns
module pcr_sync2 #(
  parameter W = 18
) (
  // clock and reset
  input  wire         sys_clk,
  input  wire         rst,
  // asynchronous in, synchronised out
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_q;

  // first stage feeds only the second stage
  always @(posedge sys_clk) begin
    if (rst) begin
      meta_q   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // pcr_sync2

/* File: tb/pcr_receiver_chk.sv */
// port checker for the packet capture receiver
// assumes binding onto pcr_receiver; sees its ports only
`timescale 1ns/1ns
module pcr_receiver_chk (
  input wire        sys_clk,
  input wire        rst,
  input wire [3:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        port_clock,
  input wire        port_frame,
  input wire        mem_wr_valid,
  input wire        mem_wr_ready,
  input wire [15:0] mem_wr_addr,
  input wire [15:0] mem_wr_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  reg       on_q;
  reg       pc_q;
  reg [7:0] age_q;
  // age of a frame begun while on; margin covers the port synchroniser
  always @(posedge sys_clk) begin
    pc_q <= port_clock;
    if (rst)
      on_q <= 1'b0;
    else if (reg_wr && reg_addr == 4'h0)
      on_q <= reg_wdata[3:0] != 4'h5;
    if (rst || !port_frame)
      age_q <= 8'h0;
    else if (port_clock && !pc_q && on_q && age_q == 8'h0)
      age_q <= 8'h1;
    else if (age_q != 8'h0 && age_q != 8'hff)
      age_q <= age_q + 8'h1;
  end
  sequence ctrl_wr; reg_wr && reg_addr == 4'h0; endsequence
  sequence ctrl_rd; reg_rd && reg_addr == 4'h0; endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside a read");
  a_unmapped_zero: assert property
    (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (ctrl_wr ##1 ctrl_rd |=>
    reg_rdata[6:0] == $past(reg_wdata[6:0], 2))
    else $error("control field readback wrong");
  a_reset_quiet: assert property
    ($fell(rst) |-> !mem_wr_valid && reg_rdata == 32'h0)
    else $error("outputs active after reset");
  a_mem_hold: assert property (mem_wr_valid && !mem_wr_ready |=>
    mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data))
    else $error("memory write dropped while stalled");
  a_addr_step: assert property (mem_wr_valid && mem_wr_ready |=>
    !mem_wr_valid || mem_wr_addr == $past(mem_wr_addr) + 16'h1)
    else $error("memory address not sequential");
  a_busy_drain: assert property ((mem_wr_valid && $past(mem_wr_valid))
    ##0 ctrl_rd |=> reg_rdata[8])
    else $error("busy low with buffered data");
  a_busy_early: assert property (age_q > 8'h8 ##0 ctrl_rd
    |=> reg_rdata[8])
    else $error("busy low during reception");
endmodule // pcr_receiver_chk
bind pcr_receiver pcr_receiver_chk chk (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .port_clock(port_clock), .port_frame(port_frame),
  .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
  .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data)
);

/* File: tb/pcr_receiver_tb_top.sv */
// bench for the packet capture receiver: register tasks, packet cases
// assumes the source model and the bound port checker
`timescale 1ns/1ns
module pcr_receiver_tb_top;
  localparam [95:0] PAT = 96'h8e3c51a7f026d4b93c85e16b;
  reg         sys_clk, rst, reg_wr, reg_rd, mem_wr_ready;
  reg  [3:0]  reg_addr;
  reg  [31:0] reg_wdata;
  wire [31:0] reg_rdata;
  wire        port_clock, port_frame, mem_wr_valid;
  wire [15:0] port_data, mem_wr_addr, mem_wr_data;
  integer     fails, comparisons, cycles, nwr, i;
  reg  [15:0] exp_q[$];
  pcr_src_model src (.port_clock(port_clock), .port_frame(port_frame),
    .port_data(port_data));
  pcr_receiver dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port_clock(port_clock),
    .port_frame(port_frame), .port_data(port_data),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));
  task end_sim;
    begin
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // tasks start right after an edge, so strobes may run back to back
  task wr(input [3:0] a, input [31:0] d);
    begin
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [31:0] exp);
    begin
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
    end
  endtask
  task push(input integer n);
    for (i = 0; i < n; i = i + 1) exp_q.push_back(PAT[95-16*i -: 16]);
  endtask
  // packet count just before and just after the done edge
  task cnt_at(input integer n, input [31:0] k);
    begin
      wait (src.edges == n + 2);
      repeat (4) @(posedge sys_clk);
      rd(4'hc, k - 32'h1);
      wait (src.edges == n + 3);
      repeat (6) @(posedge sys_clk);
      rd(4'hc, k);
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      end_sim;
    end
    if (!rst && mem_wr_valid && mem_wr_ready) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk({16'h0, mem_wr_data}, {16'h0, exp_q.pop_front()});
      chk({16'h0, mem_wr_addr}, 32'h100 + nwr);
      nwr = nwr + 1;
    end
  end
  initial begin
    {rst, reg_wr, reg_rd, mem_wr_ready} = 4'b1001;
    reg_addr    = 4'h0;
    reg_wdata   = 32'h0;
    fails       = 0;
    comparisons = 0;
    cycles      = 0;
    nwr         = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(4'h0, 32'h5);
    rd(4'h2, 32'h0);
    wr(4'h4, 32'h100);
    // module is off, so this frame must leave no trace
    src.send(2, 16, PAT);
    repeat (20) @(posedge sys_clk);
    rd(4'hc, 32'h0);
    wr(4'h0, 32'h14a);
    rd(4'h0, 32'h4a);
    push(6);
    fork
      src.send(6, 16, PAT);
      cnt_at(6, 32'h1);
    join
    @(posedge sys_clk);
    wr(4'h0, 32'ha);
    push(5);
    exp_q.push_back({8'h0, PAT[15:8]});
    fork
      src.send(88, 1, PAT);
      begin
        wait (src.edges == 3);
        repeat (4) @(posedge sys_clk);
        rd(4'h0, 32'h10a);
        wr(4'h0, 32'h5);
        cnt_at(88, 32'h2);
      end
    join
    repeat (760) @(posedge sys_clk);
    rd(4'h0, 32'h5);
    chk(exp_q.size(), 32'h0);
    // narrow widths, one word each
    wr(4'h0, 32'h2a);
    push(1);
    src.send(4, 4, PAT);
    @(posedge sys_clk);
    wr(4'h0, 32'h1a);
    push(1);
    src.send(8, 2, PAT);
    @(posedge sys_clk);
    // memory stalls while a short packet fills the buffer
    wr(4'h0, 32'h3a);
    mem_wr_ready <= 1'b0;
    push(2);
    src.send(4, 8, PAT);
    @(posedge sys_clk);
    rd(4'h0, 32'h13a);
    mem_wr_ready <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rd(4'h0, 32'h3a);
    chk(exp_q.size(), 32'h0);
    rd(4'h4, 32'h100);
    rd(4'h8, 32'h10);
    rd(4'hc, 32'h5);
    end_sim;
  end
endmodule // pcr_receiver_tb_top

/* File: tb/pcr_src_model.sv */
// packet source model: port clock, frame and data for one packet
// assumes the bench calls send; clock stands still between packets
`timescale 1ns/1ns
module pcr_src_model (
  // port side
  output reg        port_clock,
  output reg        port_frame,
  output reg [15:0] port_data
);
  integer edges;
  initial begin
    port_clock = 1'b0;
    port_frame = 1'b0;
    port_data  = 16'h0;
    edges      = 0;
  end
  // w bits per beat, earliest bits first, on the low data pins
  task send(input integer beats, input integer w, input [95:0] pat);
    integer    i;
    reg [95:0] sh;
    begin
      edges = 0;
      for (i = 0; i < beats + 5; i = i + 1) begin
        port_frame = i < beats;
        sh = pat << (w * i);
        // released data flips so a stale value never looks valid
        port_data = (i >= beats) ? ~port_data : sh[95:80] >> (16 - w);
        #40 port_clock = 1'b1;
        edges = edges + 1;
        #80 port_clock = 1'b0;
        #40;
      end
    end
  endtask
endmodule // pcr_src_model
